// ===== floppy_host_command_transfer_pkg.sv
// Purpose: Shared constants for the floppy host command and byte transfer block
// Assumes: 10 MHz mclk, one sector of 128 bytes
// Notes:   Function codes are the 3-bit function field of the command word
package floppy_host_command_transfer_pkg;
    // ----------------------------------------------------------------
    // Command word layout
    // ----------------------------------------------------------------
    localparam int GO_BIT = 0;
    localparam int FUNC_LO = 1;
    localparam int DRIVE_SEL_BIT = 4;
    localparam int INIT_BIT = 14;
    // ----------------------------------------------------------------
    // Function field codes
    // ----------------------------------------------------------------
    localparam logic [2:0] FN_FILL = 3'h0;
    localparam logic [2:0] FN_EMPTY = 3'h1;
    localparam logic [2:0] FN_WRITE = 3'h2;
    localparam logic [2:0] FN_READ = 3'h3;
    localparam logic [2:0] FN_READ_STATUS = 3'h5;
    localparam logic [2:0] FN_WRITE_DELETED = 3'h6;
    localparam logic [2:0] FN_READ_ERROR = 3'h7;
    // ----------------------------------------------------------------
    // Error status layout and error codes
    // ----------------------------------------------------------------
    localparam int ES_CRC_BIT = 0;
    localparam int ES_PARITY_BIT = 1;
    localparam int ES_INIT_DONE_BIT = 2;
    localparam int ES_DRIVE_READY_BIT = 7;
    localparam logic [15:0] ES_RESET = 16'h0000;
    localparam logic [7:0] ERR_NONE = 8'h00;
    localparam logic [7:0] ERR_BAD_SECTOR = 8'h01;
    localparam logic [7:0] ERR_BAD_TRACK = 8'h02;
    localparam logic [7:0] ERR_PARITY = 8'h03;
    // ----------------------------------------------------------------
    // Address limits and buffer size
    // ----------------------------------------------------------------
    localparam logic [7:0] SECTOR_MIN = 8'h01;
    localparam logic [7:0] SECTOR_MAX = 8'h1A;
    localparam logic [7:0] TRACK_MAX = 8'h4C;
    localparam int BUF_DEPTH = 128;
    localparam logic [6:0] BUF_LAST = 7'h7F;
    // ----------------------------------------------------------------
    // Timing
    // ----------------------------------------------------------------
    localparam int CLK_KHZ = 10000;
    localparam int READ_STATUS_MS = 250;
    localparam int READ_STATUS_CYCLES = READ_STATUS_MS * CLK_KHZ;
    localparam int SECTOR_OP_CYCLES = 1000;
    localparam int TIMER_W = 22;
endpackage

// ===== floppy_host_command_transfer.sv
// Purpose: Host-facing command interpreter and sector buffer byte transfer
// Assumes: Host strobes are one-cycle pulses synchronous to mclk
// Notes:   Media transfer and the drive mechanics are outside this block
`timescale 1ns/1ps
`default_nettype none
module floppy_host_command_transfer #(
    parameter int READ_STATUS_CYCLES = floppy_host_command_transfer_pkg::READ_STATUS_CYCLES, // Read status time
    parameter int SECTOR_OP_CYCLES = floppy_host_command_transfer_pkg::SECTOR_OP_CYCLES      // Sector access time
) (
    input wire logic mclk,                    // Clock, 10 MHz
    input wire logic reset_n,                 // Synchronous reset, active low
    input wire logic cmd_wr,                  // Command word write strobe
    input wire logic [15:0] cmd_wdata,        // Command word
    input wire logic data_wr,                 // Data register write strobe
    input wire logic [7:0] data_wdata,        // Byte written by host
    input wire logic data_rd,                 // Data register read strobe
    input wire logic parity_error,            // Host bus parity error pulse
    input wire logic power_fail,              // Power failure pulse
    input wire logic drive_ready_0,           // Drive 0 ready level
    input wire logic drive_ready_1,           // Drive 1 ready level
    output logic [15:0] byte_transfer_reg,    // Interface register read data
    output logic transfer_request_flag,       // Byte wanted or offered
    output logic done,                        // Function complete
    output logic error_flag,                  // Function ended in error
    output logic [2:0] active_function,       // Function being run
    output logic drive_select,                // Drive of last drive command
    output logic selected_drive_ready,        // Ready of selected drive at read status; drive 0 after initialize or power fail
    output logic [15:0] error_status_reg      // Error status word
);
    // ----------------------------------------------------------------
    // State
    // ----------------------------------------------------------------
    typedef enum logic [2:0] {IDLE, FILL_XFER, EMPTY_XFER, GET_SECTOR, GET_TRACK, WAIT_TIMER, FINISH} state_t;

    state_t state, next_state;
    logic [7:0] sbuf [floppy_host_command_transfer_pkg::BUF_DEPTH];
    logic [7:0] next_sbuf [floppy_host_command_transfer_pkg::BUF_DEPTH];
    logic [6:0] idx, next_idx;
    logic [7:0] sector, next_sector;
    logic [7:0] error_code, next_error_code;
    logic [floppy_host_command_transfer_pkg::TIMER_W-1:0] timer, next_timer;
    logic [15:0] next_byte_transfer_reg;
    logic next_transfer_request_flag;
    logic next_done;
    logic next_error_flag;
    logic [2:0] next_active_function;
    logic next_drive_select;
    logic next_selected_drive_ready;
    logic [15:0] next_error_status_reg;

    // Function decode used only at command entry
    function automatic logic is_sector_fn(input logic [2:0] fn);
        is_sector_fn = (fn == floppy_host_command_transfer_pkg::FN_WRITE) ||
                       (fn == floppy_host_command_transfer_pkg::FN_READ) ||
                       (fn == floppy_host_command_transfer_pkg::FN_WRITE_DELETED);
    endfunction

    localparam logic [floppy_host_command_transfer_pkg::TIMER_W-1:0] RS_LOAD =
        floppy_host_command_transfer_pkg::TIMER_W'(READ_STATUS_CYCLES - 1);
    localparam logic [floppy_host_command_transfer_pkg::TIMER_W-1:0] SO_LOAD =
        floppy_host_command_transfer_pkg::TIMER_W'(SECTOR_OP_CYCLES - 1);

    // ----------------------------------------------------------------
    // Next-state logic
    // ----------------------------------------------------------------
    // One process for the whole controller; the buffer is tiny so its copy costs nothing real
    always_comb begin
        next_state = state;
        next_sbuf = sbuf;
        next_idx = idx;
        next_sector = sector;
        next_error_code = error_code;
        next_timer = timer;
        next_byte_transfer_reg = byte_transfer_reg;
        next_transfer_request_flag = transfer_request_flag;
        next_done = done;
        next_error_flag = error_flag;
        next_active_function = active_function;
        next_drive_select = drive_select;
        next_selected_drive_ready = selected_drive_ready;
        next_error_status_reg = error_status_reg;

        // Host access clears the request; the state machine raises it again a cycle later
        if (data_rd || data_wr) begin
            next_transfer_request_flag = 1'b0;
        end

        case (state)
            IDLE: begin
                if (cmd_wr && cmd_wdata[floppy_host_command_transfer_pkg::INIT_BIT]) begin
                    // Initialize reports drive 0 whatever the select bit says
                    next_selected_drive_ready = drive_ready_0;
                    next_error_status_reg = floppy_host_command_transfer_pkg::ES_RESET;
                    next_error_status_reg[floppy_host_command_transfer_pkg::ES_INIT_DONE_BIT] = 1'b1;
                    next_error_status_reg[floppy_host_command_transfer_pkg::ES_DRIVE_READY_BIT] = drive_ready_0;
                    next_error_code = floppy_host_command_transfer_pkg::ERR_NONE;
                    next_state = FINISH;
                end else if (cmd_wr && cmd_wdata[floppy_host_command_transfer_pkg::GO_BIT]) begin
                    next_active_function = cmd_wdata[floppy_host_command_transfer_pkg::FUNC_LO +: 3];
                    next_done = 1'b0;
                    next_error_flag = 1'b0;
                    next_idx = 7'h00;
                    next_error_status_reg[floppy_host_command_transfer_pkg::ES_PARITY_BIT] = 1'b0;
                    next_error_status_reg[floppy_host_command_transfer_pkg::ES_INIT_DONE_BIT] = 1'b0;
                    // Buffer functions keep the previous drive select untouched
                    if (!(cmd_wdata[3:1] == floppy_host_command_transfer_pkg::FN_FILL ||
                          cmd_wdata[3:1] == floppy_host_command_transfer_pkg::FN_EMPTY)) begin
                        next_drive_select = cmd_wdata[floppy_host_command_transfer_pkg::DRIVE_SEL_BIT];
                    end
                    next_transfer_request_flag = 1'b1;
                    case (cmd_wdata[3:1])
                        floppy_host_command_transfer_pkg::FN_FILL: begin
                            next_state = FILL_XFER;
                        end
                        floppy_host_command_transfer_pkg::FN_EMPTY: begin
                            next_byte_transfer_reg = {8'h00, sbuf[0]};
                            next_state = EMPTY_XFER;
                        end
                        floppy_host_command_transfer_pkg::FN_READ_STATUS: begin
                            next_transfer_request_flag = 1'b0;
                            next_timer = RS_LOAD;
                            next_state = WAIT_TIMER;
                        end
                        floppy_host_command_transfer_pkg::FN_READ_ERROR: begin
                            next_transfer_request_flag = 1'b0;
                            next_state = FINISH;
                        end
                        default: begin
                            if (is_sector_fn(cmd_wdata[3:1])) begin
                                next_state = GET_SECTOR;
                            end else begin
                                // Unused code: finish at once, no drive activity
                                next_transfer_request_flag = 1'b0;
                                next_state = FINISH;
                            end
                        end
                    endcase
                end
            end

            FILL_XFER: begin
                // Request drops for a cycle after each byte so the host sees it clear
                if (data_wr) begin
                    next_sbuf[idx] = data_wdata;
                    if (idx == floppy_host_command_transfer_pkg::BUF_LAST) begin
                        next_state = FINISH;
                    end else begin
                        next_idx = idx + 7'h01;
                    end
                end else if (!transfer_request_flag) begin
                    next_transfer_request_flag = 1'b1;
                end
            end

            EMPTY_XFER: begin
                // Next byte is loaded at the access; its request follows a cycle later
                if (data_rd) begin
                    if (idx == floppy_host_command_transfer_pkg::BUF_LAST) begin
                        next_state = FINISH;
                    end else begin
                        next_idx = idx + 7'h01;
                        next_byte_transfer_reg = {8'h00, sbuf[idx + 7'h01]};
                    end
                end else if (!transfer_request_flag) begin
                    next_transfer_request_flag = 1'b1;
                end
            end

            GET_SECTOR: begin
                // Sector byte comes first, track byte second
                if (data_wr) begin
                    next_sector = data_wdata;
                    next_state = GET_TRACK;
                end
            end

            GET_TRACK: begin
                if (data_wr) begin
                    next_timer = SO_LOAD;
                    next_state = WAIT_TIMER;
                    // Bad addresses end the function without drive access
                    if (sector < floppy_host_command_transfer_pkg::SECTOR_MIN ||
                        sector > floppy_host_command_transfer_pkg::SECTOR_MAX) begin
                        next_error_code = floppy_host_command_transfer_pkg::ERR_BAD_SECTOR;
                        next_error_flag = 1'b1;
                        next_state = FINISH;
                    end else if (data_wdata > floppy_host_command_transfer_pkg::TRACK_MAX) begin
                        next_error_code = floppy_host_command_transfer_pkg::ERR_BAD_TRACK;
                        next_error_flag = 1'b1;
                        next_state = FINISH;
                    end
                end else if (!transfer_request_flag) begin
                    // Track request follows the sector byte a cycle later
                    next_transfer_request_flag = 1'b1;
                end
            end

            WAIT_TIMER: begin
                if (timer == '0) begin
                    if (active_function == floppy_host_command_transfer_pkg::FN_READ_STATUS) begin
                        next_selected_drive_ready = drive_select ? drive_ready_1 : drive_ready_0;
                        next_error_status_reg[floppy_host_command_transfer_pkg::ES_DRIVE_READY_BIT] =
                            drive_select ? drive_ready_1 : drive_ready_0;
                    end
                    next_state = FINISH;
                end else begin
                    next_timer = timer - 1'b1;
                end
            end

            FINISH: begin
                next_done = 1'b1;
                next_transfer_request_flag = 1'b0;
                next_state = IDLE;
                if (active_function == floppy_host_command_transfer_pkg::FN_READ_ERROR) begin
                    next_byte_transfer_reg = {8'h00, error_code};
                end else begin
                    next_byte_transfer_reg = error_status_reg;
                end
            end

            default: begin
                next_state = IDLE;
            end
        endcase

        // Parity error outside IDLE overrides whatever error was being reported
        if (parity_error && state != IDLE) begin
            next_error_code = floppy_host_command_transfer_pkg::ERR_PARITY;
            next_error_flag = 1'b1;
            next_error_status_reg[floppy_host_command_transfer_pkg::ES_PARITY_BIT] = 1'b1;
            if (state == FINISH) begin
                next_byte_transfer_reg = {8'h00, floppy_host_command_transfer_pkg::ERR_PARITY};
            end
        end

        // Power failure aborts any function and ends with init done set and selected_drive_ready taken from drive 0
        if (power_fail) begin
            next_error_status_reg[floppy_host_command_transfer_pkg::ES_INIT_DONE_BIT] = 1'b1;
            next_selected_drive_ready = drive_ready_0;
            next_transfer_request_flag = 1'b0;
            next_state = FINISH;
        end
    end

    // ----------------------------------------------------------------
    // Registers
    // ----------------------------------------------------------------
    // Synchronous reset; buffer contents are left unreset as data
    always_ff @(posedge mclk) begin
        sbuf <= next_sbuf;
        if (!reset_n) begin
            state <= IDLE;
            idx <= 7'h00;
            sector <= 8'h00;
            error_code <= floppy_host_command_transfer_pkg::ERR_NONE;
            timer <= '0;
            byte_transfer_reg <= 16'h0000;
            transfer_request_flag <= 1'b0;
            done <= 1'b0;
            error_flag <= 1'b0;
            active_function <= floppy_host_command_transfer_pkg::FN_FILL;
            drive_select <= 1'b0;
            selected_drive_ready <= 1'b0;
            error_status_reg <= floppy_host_command_transfer_pkg::ES_RESET;
        end else begin
            state <= next_state;
            idx <= next_idx;
            sector <= next_sector;
            error_code <= next_error_code;
            timer <= next_timer;
            byte_transfer_reg <= next_byte_transfer_reg;
            transfer_request_flag <= next_transfer_request_flag;
            done <= next_done;
            error_flag <= next_error_flag;
            active_function <= next_active_function;
            drive_select <= next_drive_select;
            selected_drive_ready <= next_selected_drive_ready;
            error_status_reg <= next_error_status_reg;
        end
    end
endmodule // floppy_host_command_transfer
`default_nettype wire

// ===== floppy_host_command_transfer_checker.sv
// Purpose: Port-level assertions for the floppy host command and byte transfer block
// Assumes: Single mclk domain, synchronous active-low reset
// Notes:   Bound to every instance of the design by the bind after the module
`timescale 1ns/1ps
`default_nettype none
module floppy_host_command_transfer_checker #(
    parameter int READ_STATUS_CYCLES = 20, // Read status time
    parameter int SECTOR_OP_CYCLES = 10    // Sector access time
) (
    input wire logic mclk,                  // Clock
    input wire logic reset_n,               // Reset, active low
    input wire logic cmd_wr,                // Command strobe
    input wire logic [15:0] cmd_wdata,      // Command word
    input wire logic data_wr,               // Data write strobe
    input wire logic [7:0] data_wdata,      // Data byte
    input wire logic data_rd,               // Data read strobe
    input wire logic parity_error,          // Parity pulse
    input wire logic power_fail,            // Power fail pulse
    input wire logic drive_ready_0,         // Drive 0 ready
    input wire logic drive_ready_1,         // Drive 1 ready
    input wire logic [15:0] byte_transfer_reg, // Interface register
    input wire logic transfer_request_flag, // Transfer request
    input wire logic done,                  // Done
    input wire logic error_flag,            // Error
    input wire logic [2:0] active_function, // Running function
    input wire logic drive_select,          // Selected drive
    input wire logic selected_drive_ready,  // Selected drive ready
    input wire logic [15:0] error_status_reg // Error status
);
    // ----------------------------------------------------------------
    // Assertions, all on mclk and quiet during reset
    // ----------------------------------------------------------------
    default clocking cb @(posedge mclk); endclocking
    default disable iff (!reset_n);

    // Idle empty command must offer the first byte at once
    empty_starts_a: assert property (cmd_wr && done && !cmd_wdata[14] && cmd_wdata[3:0] == 4'h3
        |=> transfer_request_flag && !done) else $error("empty buffer did not raise transfer request");
    no_tr_done_a: assert property (!(transfer_request_flag && done))
        else $error("transfer request and done both high");
    tr_clears_a: assert property (transfer_request_flag && (data_rd || data_wr) |=> !transfer_request_flag)
        else $error("transfer request not cleared by data access");
    // Status word must sit in the interface register whenever a non-error-code function ends
    status_at_done_a: assert property ($rose(done) && active_function != floppy_host_command_transfer_pkg::FN_READ_ERROR
        |-> byte_transfer_reg == error_status_reg) else $error("status word missing at done");
    power_fail_done_a: assert property (power_fail |-> ##[1:8] (done && error_status_reg[2]))
        else $error("power fail did not end in done with init done");
    ready_report_a: assert property ($rose(done) && active_function == floppy_host_command_transfer_pkg::FN_READ_STATUS
        // A read status cut short by power fail carries init done and reports drive 0
        && !error_status_reg[2] |-> selected_drive_ready == (drive_select ? drive_ready_1 : drive_ready_0)
        && error_status_reg[7] == selected_drive_ready) else $error("selected drive ready wrong after read status");
    status_slow_a: assert property (cmd_wr && done && !cmd_wdata[14] && cmd_wdata[3:0] == 4'hB
        |=> !done [*8]) else $error("read status finished too soon");
    buffer_no_drive_a: assert property (cmd_wr && done && !cmd_wdata[14] && cmd_wdata[0] && cmd_wdata[3:2] == 2'b00
        |=> $stable(drive_select)) else $error("buffer function loaded drive select");
    error_ends_a: assert property ($rose(error_flag) |-> ##[0:1] done)
        else $error("error flag without done");

    // Main scenarios reached
    empty_seen_c: cover property (active_function == floppy_host_command_transfer_pkg::FN_EMPTY && $rose(done));
    power_seen_c: cover property (power_fail ##[1:8] done);
    error_seen_c: cover property ($rose(error_flag));
endmodule // floppy_host_command_transfer_checker

bind floppy_host_command_transfer floppy_host_command_transfer_checker #(
    .READ_STATUS_CYCLES(READ_STATUS_CYCLES), .SECTOR_OP_CYCLES(SECTOR_OP_CYCLES)
) chk_u (.mclk(mclk), .reset_n(reset_n), .cmd_wr(cmd_wr), .cmd_wdata(cmd_wdata), .data_wr(data_wr),
    .data_wdata(data_wdata), .data_rd(data_rd), .parity_error(parity_error), .power_fail(power_fail),
    .drive_ready_0(drive_ready_0), .drive_ready_1(drive_ready_1), .byte_transfer_reg(byte_transfer_reg),
    .transfer_request_flag(transfer_request_flag), .done(done), .error_flag(error_flag),
    .active_function(active_function), .drive_select(drive_select),
    .selected_drive_ready(selected_drive_ready), .error_status_reg(error_status_reg));
`default_nettype wire

// ===== testbench.sv
// Purpose: Self-checking bench for the floppy host command and byte transfer block
// Assumes: Short read status and sector timings set by parameter
// Notes:   Buffer model is a queue; host strobes driven 1 ns after the edge
`timescale 1ns/1ps
`default_nettype none
module testbench;
    localparam int RS = 20;
    localparam int SO = 10;
    logic mclk = 1'b0;
    logic reset_n = 1'b0;
    logic cmd_wr = 1'b0;
    logic [15:0] cmd_wdata = 16'h0000;
    logic data_wr = 1'b0;
    logic [7:0] data_wdata = 8'h00;
    logic data_rd = 1'b0;
    logic parity_error = 1'b0;
    logic power_fail = 1'b0;
    logic drive_ready_0 = 1'b0;
    logic drive_ready_1 = 1'b0;
    logic [15:0] byte_transfer_reg, error_status_reg;
    logic transfer_request_flag, done, error_flag, drive_select, selected_drive_ready;
    logic [2:0] active_function;
    int fail_count = 0;
    int checks_done = 0;
    int n;
    logic [7:0] model_buf[$];
    logic [7:0] b;
    // Sector cases: command, sector, track, expected error code
    logic [15:0] sc_cmd[5] = '{16'h0005, 16'h0007, 16'h000D, 16'h0005, 16'h0007};
    logic [7:0] sc_sec[5] = '{8'h01, 8'h1A, 8'h00, 8'h1B, 8'h05};
    logic [7:0] sc_trk[5] = '{8'h00, 8'h4C, 8'h05, 8'h03, 8'h4D};
    logic [7:0] sc_err[5] = '{8'h00, 8'h00, 8'h01, 8'h01, 8'h02};

    floppy_host_command_transfer #(.READ_STATUS_CYCLES(RS), .SECTOR_OP_CYCLES(SO)) dut_u (
        .mclk(mclk), .reset_n(reset_n), .cmd_wr(cmd_wr), .cmd_wdata(cmd_wdata), .data_wr(data_wr),
        .data_wdata(data_wdata), .data_rd(data_rd), .parity_error(parity_error), .power_fail(power_fail),
        .drive_ready_0(drive_ready_0), .drive_ready_1(drive_ready_1), .byte_transfer_reg(byte_transfer_reg),
        .transfer_request_flag(transfer_request_flag), .done(done), .error_flag(error_flag),
        .active_function(active_function), .drive_select(drive_select),
        .selected_drive_ready(selected_drive_ready), .error_status_reg(error_status_reg));

    // ----------------------------------------------------------------
    // Clock and shared tasks
    // ----------------------------------------------------------------
    always #50 mclk = ~mclk;

    // Inputs move 1 ns after the edge so the design never sees a race
    task automatic tick(input int k = 1);
        repeat (k) @(posedge mclk);
        #1;
    endtask

    task automatic check(input logic [15:0] got, input logic [15:0] exp);
        checks_done++;
        if (got !== exp) begin
            fail_count++;
            $display("FAIL at %0t got %h expected %h", $time, got, exp);
        end
    endtask

    task automatic command(input logic [15:0] w);
        cmd_wr = 1'b1;
        cmd_wdata = w;
        tick();
        cmd_wr = 1'b0;
    endtask

    // Bounded wait; n holds the edges taken so latencies can be compared
    task automatic wait_done(input int lim);
        n = 0;
        while (done !== 1'b1 && n < lim) begin
            tick();
            n++;
        end
        check({15'h0000, done}, 16'h0001);
    endtask

    // One byte per request; a read compares the offered byte first
    task automatic byte_io(input logic wr, input logic [7:0] v);
        int k;
        k = 0;
        while (transfer_request_flag !== 1'b1 && k < 8) begin
            tick();
            k++;
        end
        check({15'h0000, transfer_request_flag}, 16'h0001);
        if (!wr) check({8'h00, byte_transfer_reg[7:0]}, {8'h00, v});
        data_wr = wr;
        data_rd = !wr;
        data_wdata = v;
        tick();
        data_wr = 1'b0;
        data_rd = 1'b0;
        check({15'h0000, transfer_request_flag}, 16'h0000);
    endtask

    task automatic tally_and_finish;
        $display("Counts: %0d checks, %0d mismatches", checks_done, fail_count);
        if (fail_count == 0 && checks_done > 0)
            $display("Finished cleanly");
        else
            $display("Finished with errors");
        $finish;
    endtask

    // ----------------------------------------------------------------
    // Watchdog, generous against about 900 expected cycles
    // ----------------------------------------------------------------
    initial begin
        #(100 * 8000);
        fail_count++;
        tally_and_finish();
    end

    // ----------------------------------------------------------------
    // Main sequence
    // ----------------------------------------------------------------
    initial begin
        void'($urandom(32'h0d18d127));
        tick(3);
        check({13'h0000, done, transfer_request_flag, error_flag}, 16'h0000);
        check(error_status_reg, 16'h0000);
        reset_n = 1'b1;
        drive_ready_1 = 1'($urandom);
        drive_ready_0 = ~drive_ready_1;
        command(16'h001B);
        wait_done(RS + 8);
        check(16'(n), 16'(RS + 1));
        check({15'h0000, selected_drive_ready}, {15'h0000, drive_ready_1});
        check({15'h0000, error_status_reg[7]}, {15'h0000, drive_ready_1});
        check(byte_transfer_reg, {8'h00, drive_ready_1, 7'h00});
        $display("read status test ended");
        command(16'h0001);
        for (int i = 0; i < floppy_host_command_transfer_pkg::BUF_DEPTH; i++) begin
            b = 8'($urandom);
            model_buf.push_back(b);
            byte_io(1'b1, b);
        end
        wait_done(4);
        check(16'(n), 16'h0001);
        check({15'h0000, drive_select}, 16'h0001);
        $display("fill test ended");
        command(16'h0003);
        foreach (model_buf[i]) byte_io(1'b0, model_buf[i]);
        wait_done(4);
        check(16'(n), 16'h0001);
        check({15'h0000, transfer_request_flag}, 16'h0000);
        check(byte_transfer_reg, {8'h00, drive_ready_1, 7'h00});
        $display("empty test ended");
        for (int i = 0; i < 5; i++) begin
            command(sc_cmd[i]);
            check({13'h0000, active_function}, {13'h0000, sc_cmd[i][3:1]});
            byte_io(1'b1, sc_sec[i]);
            byte_io(1'b1, sc_trk[i]);
            wait_done(SO + 8);
            check({15'h0000, error_flag}, {15'h0000, sc_err[i] != 8'h00});
            if (sc_err[i] != 8'h00) begin
                command(16'h000F);
                wait_done(4);
                check({8'h00, byte_transfer_reg[7:0]}, {8'h00, sc_err[i]});
            end
        end
        $display("sector address test ended");
        command(16'h000F);
        parity_error = 1'b1;
        tick();
        parity_error = 1'b0;
        wait_done(4);
        check({8'h00, byte_transfer_reg[7:0]}, {8'h00, floppy_host_command_transfer_pkg::ERR_PARITY});
        $display("parity test ended");
        // One clean retry of empty buffer after the parity error
        command(16'h0003);
        foreach (model_buf[i]) byte_io(1'b0, model_buf[i]);
        wait_done(4);
        check({15'h0000, error_flag}, 16'h0000);
        $display("retry test ended");
        command(16'h000B);
        tick(10);
        power_fail = 1'b1;
        tick();
        power_fail = 1'b0;
        wait_done(8);
        check({15'h0000, error_status_reg[2]}, 16'h0001);
        check({15'h0000, selected_drive_ready}, {15'h0000, drive_ready_0});
        command(16'h4000);
        wait_done(4);
        check({15'h0000, selected_drive_ready}, {15'h0000, drive_ready_0});
        $display("power fail and initialize test ended");
        tally_and_finish();
    end
endmodule // testbench
`default_nettype wire
